// ===== rtl/exec_map.svh
/*
 Register offsets, flag positions, opcodes, cycle counts and reset values
 of the instruction execution unit. Included by the package users only.
*/
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
`define OFS_INSTR 8'h00
`define OFS_FLAGS 8'h04
`define OFS_MODE  8'h08
`define OFS_PC    8'h0C
`define OFS_SP    8'h10
`define OFS_STAT  8'h14
`define OFS_PEND  8'h18
`define RF_PAGE   2'b01
`define FL_C      7
`define FL_Z      6
`define FL_S      5
`define FL_V      4
`define MODE_IE   2
`define OP_SUB1_R 8'h00
`define OP_SUB1_P 8'h01
`define OP_INC_R  8'h20
`define OP_INC_P  8'h21
`define OP_JUMP   8'h30
`define OP_IOFF   8'h8F
`define OP_ION    8'h9F
`define OP_IDLE   8'h6F
`define OP_RETI   8'hBF
`define LO_INC    4'hE
`define LO_JUMPC  4'hD
`define CYC_4     4'h4
`define CYC_6     4'h6
`define CYC_8     4'h8
`define OVF_SUB1  8'h80
`define OVF_INC   8'h7F
`define RST_PC    16'h0000
`define RST_SP    8'h00
`define RST_SYM   8'h00
`define RST_FLAGS 8'h00
`define VEC_BASE  16'h0100
`endif

// ===== rtl/exec_pkg.sv
/*
 Types of the instruction execution unit.
 Assumes nothing of its surroundings.
*/
package exec_pkg;
	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_EXEC  = 2'b01,
		ST_IDLE  = 2'b10
	} state_e;
	typedef logic [7:0] byte_t;
endpackage : exec_pkg

// ===== rtl/exec_unit.sv
/*
 Execution unit for a subset of an 8-bit instruction set, with register
 file, flags, mode register, stack and interrupt pending logic.
 Assumes one AHB-Lite master on hclk and asynchronous interrupt pins.
*/
`include "exec_map.svh"
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Decrement subtracts one; 00 full register, 01 pointer register; 2 bytes, 4 cycles
// - Decrement sets zero and sign from result; carry, decimal, half-carry kept
// - Decrement overflow only for 80H becoming 7FH, else cleared
// - Increment adds one; rE working register, 20 full, 21 pointer; 4 cycles
// - Increment sets zero and sign from result; carry, decimal, half-carry kept
// - Increment overflow only for 7FH becoming 80H, else cleared
// - Opcode 8F, 4 cycles, clears mode bit 2, disabling interrupt service
// - With service disabled requests still pend but are not vectored
// - Opcode 9F, 4 cycles, sets mode bit 2, enabling interrupt service
// - After enabling, requests pended meanwhile are serviced
// - Opcode 6F, 4 cycles, stops the CPU clock, oscillator keeps running
// - Idle ends on an interrupt request or on reset
// - Opcode BF, 6 cycles: pop flags, pop program counter, set mode bit 2
// - Interrupt return restores all flags to pre-interrupt values
// - Conditional jump ccD, 3 bytes, 8 cycles; loads address when condition holds
// - Opcode 30, 8 cycles, loads program counter from register pair, high first
// - Interrupt disable, enable, idle and jumps leave flags unchanged
module exec_unit
	import exec_pkg::*;
#(
	parameter int NIRQ = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic [NIRQ-1:0]   irq_req,
	output logic                   cpu_clock_stop,
	output logic                   vector_taken,
	output logic      [2:0]        vector_num
);

	if (NIRQ < 1 || NIRQ > 8) begin : g_bad_nirq
		$error("NIRQ must lie between 1 and 8");
	end

	state_e          state;
	state_e          next_state;
	logic [3:0]      cnt;
	byte_t           op;
	byte_t           b1;
	byte_t           b2;
	byte_t           rf [16];
	byte_t           flags;
	byte_t           mode_reg;
	byte_t           sp;
	logic [15:0]     pc;
	logic            illegal;
	logic [NIRQ-1:0] pend;
	logic [NIRQ-1:0] s1;
	logic [NIRQ-1:0] s2;
	logic [NIRQ-1:0] s3;
	logic            ap_wr;
	logic [7:0]      ap_ad;
	logic [31:0]     rd_mux;

	function automatic logic [3:0] cycles_of(input byte_t o);
		if (o == `OP_SUB1_R || o == `OP_SUB1_P || o == `OP_INC_R || o == `OP_INC_P)
			return `CYC_4;
		if (o[3:0] == `LO_INC || o == `OP_IOFF || o == `OP_ION || o == `OP_IDLE)
			return `CYC_4;
		if (o == `OP_RETI)
			return `CYC_6;
		if (o[3:0] == `LO_JUMPC || o == `OP_JUMP)
			return `CYC_8;
		return 4'h0;
	endfunction : cycles_of

	function automatic logic [15:0] len_of(input byte_t o);
		if (o[3:0] == `LO_JUMPC)
			return 16'h0003;
		if (o == `OP_SUB1_R || o == `OP_SUB1_P || o == `OP_INC_R || o == `OP_INC_P || o == `OP_JUMP)
			return 16'h0002;
		return 16'h0001;
	endfunction : len_of

	function automatic logic cond_true(input logic [3:0] cf, input byte_t f);
		logic c, z, s, v;
		c = f[`FL_C];
		z = f[`FL_Z];
		s = f[`FL_S];
		v = f[`FL_V];
		unique case (cf)
			4'h0: return 1'b0;
			4'h8: return 1'b1;
			4'h7: return c;
			4'hF: return !c;
			4'h6: return z;
			4'hE: return !z;
			4'h5: return s;
			4'hD: return !s;
			4'h4: return v;
			4'hC: return !v;
			4'h1: return s ^ v;
			4'h9: return !(s ^ v);
			4'h2: return z | (s ^ v);
			4'hA: return !(z | (s ^ v));
			4'h3: return c | z;
			4'hB: return !(c | z);
		endcase
	endfunction : cond_true

	function automatic logic [2:0] first_set(input logic [NIRQ-1:0] p);
		logic [2:0] n;
		n = 3'h0;
		for (int i = NIRQ - 1; i >= 0; i--)
			if (p[i])
				n = 3'(i);
		return n;
	endfunction : first_set

	// Bus decode
	wire       ap_ok   = hsel && hready && htrans[1];
	wire       w_instr = ap_wr && ap_ad == `OFS_INSTR;
	wire       sw_ok   = ap_wr && state != ST_EXEC;
	wire       w_rf    = sw_ok && ap_ad[7:6] == `RF_PAGE;
	wire [3:0] w_idx   = ap_ad[5:2];

	// Instruction decode
	wire is_sub1  = op == `OP_SUB1_R || op == `OP_SUB1_P;
	wire is_wr    = op[3:0] == `LO_INC;
	wire is_inc   = is_wr || op == `OP_INC_R || op == `OP_INC_P;
	wire is_ind   = op == `OP_SUB1_P || op == `OP_INC_P;
	wire is_ioff  = op == `OP_IOFF;
	wire is_ion   = op == `OP_ION;
	wire is_idle  = op == `OP_IDLE;
	wire is_reti  = op == `OP_RETI;
	wire is_jumpc = op[3:0] == `LO_JUMPC;
	wire is_jump  = op == `OP_JUMP;
	wire commit  = state == ST_EXEC && cnt == 4'h0;

	wire [3:0]  reg_idx = is_wr ? op[7:4] : b1[3:0];
	wire [3:0]  dst_idx = is_ind ? rf[reg_idx][3:0] : reg_idx;
	wire [7:0]  oper    = rf[dst_idx];
	wire [7:0]  res     = is_inc ? oper + 8'h01 : oper - 8'h01;
	wire        ovf     = is_inc ? oper == `OVF_INC : oper == `OVF_SUB1;
	wire [3:0]  si      = sp[3:0];
	wire [3:0]  pair    = b1[3:0];
	wire        cc_ok   = cond_true(op[7:4], flags);
	wire [15:0] pc_next = pc + len_of(op);

	// Interrupt edge detect and service decision
	wire [NIRQ-1:0] irq_edge = s2 & ~s3;
	wire            take     = state == ST_READY && mode_reg[`MODE_IE] && |pend;
	wire [2:0]      take_num = first_set(pend);
	wire            go       = w_instr && state == ST_READY && !take && cycles_of(hwdata[7:0]) != 4'h0;
	wire            bad      = w_instr && state == ST_READY && !take && cycles_of(hwdata[7:0]) == 4'h0;
	wire [NIRQ-1:0] sw_clr   = (sw_ok && ap_ad == `OFS_PEND) ? hwdata[NIRQ-1:0] : '0;
	wire [NIRQ-1:0] svc_clr  = take ? NIRQ'(1) << take_num : '0;

	always_comb begin
		rd_mux = 32'h0;
		if (haddr[7:6] == `RF_PAGE)
			rd_mux = {24'h0, rf[haddr[5:2]]};
		else begin
			unique case (haddr[7:0])
				`OFS_INSTR: rd_mux = {8'h0, b2, b1, op};
				`OFS_FLAGS: rd_mux = {24'h0, flags};
				`OFS_MODE:  rd_mux = {24'h0, mode_reg};
				`OFS_PC:    rd_mux = {16'h0, pc};
				`OFS_SP:    rd_mux = {24'h0, sp};
				`OFS_STAT:  rd_mux = {29'h0, illegal, state == ST_IDLE, state == ST_EXEC};
				`OFS_PEND:  rd_mux = 32'(pend);
				default:    rd_mux = 32'h0;
			endcase
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			ST_READY: if (go) next_state = ST_EXEC;
			ST_EXEC:  if (cnt == 4'h0) next_state = is_idle ? ST_IDLE : ST_READY;
			ST_IDLE:  if (|irq_edge) next_state = ST_READY;
			default:  next_state = ST_READY;
		endcase
	end

	// AHB-Lite slave, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr     <= 1'b0;
			ap_ad     <= 8'h0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ap_wr     <= ap_ok && hwrite;
			ap_ad     <= haddr[7:0];
			hrdata    <= (ap_ok && !hwrite) ? rd_mux : 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Pin synchronisers and pending bits, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			pend <= '0;
		end else begin
			s1   <= irq_req;
			s2   <= s1;
			s3   <= s2;
			pend <= (pend & ~(sw_clr | svc_clr)) | irq_edge;
		end
	end

	// Sequencer and status outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state          <= ST_READY;
			cnt            <= 4'h0;
			op             <= 8'h0;
			b1             <= 8'h0;
			b2             <= 8'h0;
			illegal        <= 1'b0;
			cpu_clock_stop <= 1'b0;
			vector_taken   <= 1'b0;
			vector_num     <= 3'h0;
		end else begin
			state <= next_state;
			cpu_clock_stop <= next_state == ST_IDLE;
			vector_taken   <= take;
			vector_num     <= take ? take_num : vector_num;
			illegal        <= bad || (illegal && !(sw_ok && ap_ad == `OFS_STAT));
			if (go) begin
				op  <= hwdata[7:0];
				b1  <= hwdata[15:8];
				b2  <= hwdata[23:16];
				cnt <= cycles_of(hwdata[7:0]) - 4'h1;
			end else if (state == ST_EXEC)
				cnt <= cnt - 4'h1;
		end
	end

	// Architectural state: software access, execution and interrupt entry
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 16; i++)
				rf[i] <= 8'h0;
			flags <= `RST_FLAGS;
			mode_reg <= `RST_SYM;
			sp    <= `RST_SP;
			pc    <= `RST_PC;
		end else if (take) begin
			rf[si - 4'h1]      <= pc[7:0];
			rf[si - 4'h2]      <= pc[15:8];
			rf[si - 4'h3]      <= flags;
			sp                 <= sp - 8'h03;
			mode_reg[`MODE_IE] <= 1'b0;
			pc                 <= `VEC_BASE + {12'h0, take_num, 1'b0};
		end else if (commit) begin
			pc <= pc_next;
			if (is_sub1 || is_inc) begin
				rf[dst_idx] <= res;
				flags[`FL_Z] <= res == 8'h00;
				flags[`FL_S] <= res[7];
				flags[`FL_V] <= ovf;
			end
			if (is_ioff) mode_reg[`MODE_IE] <= 1'b0;
			if (is_ion) mode_reg[`MODE_IE] <= 1'b1;
			// Pop flags, then counter, then enable
			if (is_reti) begin
				flags              <= rf[si];
				pc                 <= {rf[si + 4'h1], rf[si + 4'h2]};
				sp                 <= sp + 8'h03;
				mode_reg[`MODE_IE] <= 1'b1;
			end
			if (is_jumpc && cc_ok)
				pc <= {b1, b2};
			if (is_jump)
				pc <= {rf[pair], rf[pair + 4'h1]};
		end else if (w_rf)
			rf[w_idx] <= hwdata[7:0];
		else if (sw_ok) begin
			if (ap_ad == `OFS_FLAGS)
				flags <= hwdata[7:0];
			if (ap_ad == `OFS_MODE)
				mode_reg <= hwdata[7:0];
			if (ap_ad == `OFS_SP)
				sp <= hwdata[7:0];
			if (ap_ad == `OFS_PC)
				pc <= hwdata[15:0];
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_exec4;
		(state == ST_EXEC && !commit) [*3] ##1 commit;
	endsequence

	sequence s_reti_pop(byte_t f, logic [15:0] p, byte_t q);
		##1 (flags == $past(f) && pc == $past(p) && sp == $past(q) + 8'h03 && mode_reg[`MODE_IE]);
	endsequence

	AST_SUB1_RESULT: assert property (commit && is_sub1 |=> rf[$past(dst_idx)] == $past(oper) - 8'h01)
		else $error("decrement result wrong");
	AST_SUB1_FLAGS: assert property (commit && is_sub1 |=> flags[`FL_Z] == (rf[$past(dst_idx)] == 8'h00)
		&& flags[`FL_S] == rf[$past(dst_idx)][7] && flags[3:0] == $past(flags[3:0])
		&& flags[`FL_C] == $past(flags[`FL_C]))
		else $error("decrement flags wrong");
	AST_SUB1_OVF: assert property (commit && is_sub1 |=> flags[`FL_V] == ($past(oper) == `OVF_SUB1))
		else $error("decrement overflow wrong");
	AST_INC_TIME: assert property ($rose(state == ST_EXEC) && cycles_of(op) == `CYC_4 |-> s_exec4)
		else $error("four cycle instruction timing wrong");
	AST_INC_FLAGS: assert property (commit && is_inc |=> flags[`FL_Z] == (rf[$past(dst_idx)] == 8'h00)
		&& flags[`FL_S] == rf[$past(dst_idx)][7]
		&& flags[`FL_C] == $past(flags[`FL_C]) && flags[3:0] == $past(flags[3:0]))
		else $error("increment flags wrong");
	AST_INC_OVF: assert property (commit && is_inc |=> flags[`FL_V] == ($past(oper) == `OVF_INC))
		else $error("increment overflow wrong");
	AST_IOFF: assert property (commit && is_ioff |=> (!mode_reg[`MODE_IE] && !vector_taken) [*2])
		else $error("disable did not block service");
	AST_NO_VECTOR: assert property (!mode_reg[`MODE_IE] |=> !vector_taken)
		else $error("vector taken while disabled");
	AST_ION_SERVICE: assert property (commit && is_ion && |pend |=> mode_reg[`MODE_IE] ##1 vector_taken)
		else $error("pending request not serviced after enable");
	AST_IDLE: assert property (commit && is_idle |=> cpu_clock_stop)
		else $error("idle did not stop clock");
	AST_WAKE: assert property (state == ST_IDLE && |irq_edge |=> !cpu_clock_stop)
		else $error("idle not left on request");
	AST_RETI: assert property (commit && is_reti |-> s_reti_pop(rf[si], {rf[si + 4'h1], rf[si + 4'h2]}, sp))
		else $error("interrupt return wrong");
	AST_JUMP: assert property (commit && is_jump |=> pc == {$past(rf[pair]), $past(rf[pair + 4'h1])})
		else $error("register pair jump wrong");
	AST_KEEP_FLAGS: assert property (commit && (is_ioff || is_ion || is_idle || is_jump || is_jumpc)
		|=> $stable(flags))
		else $error("flags changed");

endmodule : exec_unit

`default_nettype wire

// ===== bench/prog_mem.sv
/*
 Program memory model holding the instruction words run by the bench.
 Assumes the bench reads it combinationally by index.
*/
`timescale 1ns/10ps
`default_nettype none
module prog_mem (
	input  wire logic [3:0]  addr,
	output logic      [23:0] word
);
	// Opcode in bits 7:0, first operand 15:8, second 23:16
	always_comb begin
		case (addr)
			4'h0:    word = 24'h00008F;
			4'h1:    word = 24'h00009F;
			4'h2:    word = 24'h0000BF;
			4'h3:    word = 24'h00006F;
			4'h4:    word = 24'h34128D;
			4'h5:    word = 24'h78560D;
			4'h6:    word = 24'hBC9A7D;
			4'h7:    word = 24'h1111FD;
			4'h8:    word = 24'h000430;
			default: word = 24'h00006F;
		endcase
	end
endmodule : prog_mem
`default_nettype wire

// ===== bench/tb.sv
/*
 Self-checking bench of the execution unit, driven over AHB-Lite.
 Assumes the program memory model and a 20 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "exec_map.svh"
module tb import exec_pkg::*;;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic      [31:0] haddr = 32'h0;
	logic      [1:0]  htrans = 2'b00;
	logic             hwrite = 1'b0;
	logic      [31:0] hwdata = 32'h0;
	logic      [7:0]  irq_req = 8'h00;
	wire logic [31:0] hrdata;
	wire logic        hreadyout;
	wire logic        hresp;
	wire logic        cpu_clock_stop;
	wire logic        vector_taken;
	wire logic [2:0]  vector_num;
	logic      [3:0]  pm_addr = 4'h0;
	wire logic [23:0] pm_word;
	logic      [31:0] pc0;
	int               err_count = 0;
	int               check_count = 0;
	int               cyc = 0;
	int               vt_count = 0;

	always #25 hclk = ~hclk;

	exec_unit #(.NIRQ(8)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .cpu_clock_stop(cpu_clock_stop),
		.vector_taken(vector_taken), .vector_num(vector_num));

	prog_mem pmem (.addr(pm_addr), .word(pm_word));

	// Vector pulses and hang guard
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (vector_taken === 1'b1)
			vt_count <= vt_count + 1;
		if (cyc == 20000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask : rdchk

	task automatic exec(input logic [23:0] w);
		logic [31:0] q;
		wr(`OFS_INSTR, {8'h00, w});
		for (int i = 0; i < 20; i++) begin
			bus(1'b0, `OFS_STAT, 32'h0, q);
			if (q[0] === 1'b0)
				break;
		end
	endtask : exec

	task automatic exec_pm(input logic [3:0] idx);
		pm_addr = idx;
		#1;
		exec(pm_word);
	endtask : exec_pm

	task automatic alu(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] ra,
			input logic [7:0] init, input logic [7:0] res, input logic [7:0] fl);
		wr(8'h54, 32'h07);
		wr(ra, {24'h0, init});
		wr(`OFS_FLAGS, 32'h9C);
		bus(1'b0, `OFS_PC, 32'h0, pc0);
		exec({8'h00, b1, op});
		rdchk(ra, {24'h0, res});
		rdchk(`OFS_FLAGS, {24'h0, fl});
		rdchk(`OFS_PC, {16'h0, pc0[15:0] + ((op[3:0] == `LO_INC) ? 16'h1 : 16'h2)});
	endtask : alu

	task automatic irq_flow();
		wr(`OFS_MODE, 32'h04);
		wr(`OFS_FLAGS, 32'hA4);
		exec_pm(4'h0);
		rdchk(`OFS_MODE, 32'h00);
		rdchk(`OFS_FLAGS, 32'hA4);
		irq_req <= 8'h04;
		repeat (6) @(posedge hclk);
		rdchk(`OFS_PEND, 32'h04);
		chk(vt_count, 0);
		bus(1'b0, `OFS_PC, 32'h0, pc0);
		exec_pm(4'h1);
		repeat (3) @(posedge hclk);
		chk(vt_count, 1);
		chk({29'h0, vector_num}, 32'h2);
		rdchk(`OFS_PC, 32'h0104);
		rdchk(`OFS_SP, 32'hFD);
		rdchk(`OFS_PEND, 32'h00);
		irq_req <= 8'h00;
		wr(`OFS_FLAGS, 32'h00);
		exec_pm(4'h2);
		rdchk(`OFS_FLAGS, 32'hA4);
		rdchk(`OFS_PC, {16'h0, pc0[15:0] + 16'h1});
		rdchk(`OFS_MODE, 32'h04);
		rdchk(`OFS_SP, 32'h00);
	endtask : irq_flow

	task automatic idle_flow();
		exec_pm(4'h3);
		@(posedge hclk);
		chk(cpu_clock_stop, 1'b1);
		rdchk(`OFS_FLAGS, 32'hA4);
		irq_req <= 8'h01;
		repeat (6) @(posedge hclk);
		chk(cpu_clock_stop, 1'b0);
		irq_req <= 8'h00;
	endtask : idle_flow

	task automatic jump_case(input logic [3:0] idx, input logic taken, input logic [15:0] dest);
		bus(1'b0, `OFS_PC, 32'h0, pc0);
		exec_pm(idx);
		rdchk(`OFS_PC, {16'h0, taken ? dest : pc0[15:0] + 16'h3});
	endtask : jump_case

	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		chk(hresp, 1'b0);
		alu(8'h00, 8'h03, 8'h4C, 8'h80, 8'h7F, 8'h9C);
		alu(8'h00, 8'h03, 8'h4C, 8'h01, 8'h00, 8'hCC);
		alu(8'h00, 8'h03, 8'h4C, 8'h00, 8'hFF, 8'hAC);
		alu(8'h01, 8'h05, 8'h5C, 8'h10, 8'h0F, 8'h8C);
		alu(8'h3E, 8'h00, 8'h4C, 8'h7F, 8'h80, 8'hBC);
		alu(8'h20, 8'h03, 8'h4C, 8'hFF, 8'h00, 8'hCC);
		alu(8'h21, 8'h05, 8'h5C, 8'h0F, 8'h10, 8'h8C);
		irq_flow();
		idle_flow();
		wr(`OFS_FLAGS, 32'h80);
		wr(8'h50, 32'h01);
		wr(8'h54, 32'h20);
		jump_case(4'h4, 1'b1, 16'h1234);
		jump_case(4'h5, 1'b0, 16'h0000);
		jump_case(4'h6, 1'b1, 16'h9ABC);
		jump_case(4'h7, 1'b0, 16'h0000);
		jump_case(4'h8, 1'b1, 16'h0120);
		rdchk(`OFS_FLAGS, 32'h80);
		complete_run();
	end
endmodule : tb
`default_nettype wire
